// file: rtl/hcs_pkg.sv
// Constants, hopping table and state codes for the hop carrier selector
package hcs_pkg;
  // Carrier arithmetic is done modulo the used frequency count
  localparam int unsigned    HCS_NUF         = 95;
  localparam logic [7:0]     HCS_NUF_W8      = 8'h5f;
  localparam int unsigned    HCS_CN_W        = 7;
  localparam int unsigned    HCS_MAX_EXCL    = 20;
  localparam logic [7:0]     HCS_ONE_W8      = 8'h01;
  localparam logic [7:0]     HCS_ZERO_W8     = 8'h00;
  localparam logic [2:0]     HCS_SHARED_LIM  = 3'h2;
  // Tuning word in kHz, for a 10.368000 MHz crystal
  localparam int unsigned    HCS_XTAL_KHZ    = 10368;
  localparam int unsigned    HCS_FREQ_W      = 22;
  localparam logic [21:0]    HCS_FREQ_BASE   = 22'h24a320;
  localparam logic [21:0]    HCS_FREQ_STEP   = 22'h000360;
  // Nonvolatile address of the single-antenna setting
  localparam logic [15:0]    HCS_NV_DIV_ADDR = 16'h0035;

  typedef logic [HCS_CN_W-1:0] hcs_cn_type;

  // Index to carrier map, identical in base and handset
  localparam hcs_cn_type HCS_HOP_TABLE [0:94] = '{
    7'h00, 7'h17, 7'h3e, 7'h08, 7'h2b, 7'h10, 7'h47, 7'h2f, 7'h13, 7'h3d,
    7'h4c, 7'h1d, 7'h3b, 7'h16, 7'h34, 7'h56, 7'h3f, 7'h1a, 7'h4d, 7'h1f,
    7'h02, 7'h12, 7'h51, 7'h0b, 7'h24, 7'h48, 7'h36, 7'h45, 7'h15, 7'h03,
    7'h25, 7'h0a, 7'h22, 7'h42, 7'h07, 7'h44, 7'h5e, 7'h4b, 7'h04, 7'h3c,
    7'h1b, 7'h0c, 7'h59, 7'h19, 7'h57, 7'h0e, 7'h39, 7'h29, 7'h4a, 7'h20,
    7'h46, 7'h09, 7'h3a, 7'h4e, 7'h2d, 7'h14, 7'h49, 7'h5d, 7'h40, 7'h27,
    7'h0d, 7'h21, 7'h41, 7'h32, 7'h4f, 7'h38, 7'h5b, 7'h2a, 7'h50, 7'h30,
    7'h0f, 7'h55, 7'h05, 7'h58, 7'h11, 7'h54, 7'h06, 7'h43, 7'h31, 7'h5c,
    7'h28, 7'h01, 7'h1c, 7'h37, 7'h23, 7'h35, 7'h18, 7'h2c, 7'h52, 7'h33,
    7'h5a, 7'h26, 7'h53, 7'h1e, 7'h2e
  };

  typedef enum logic [1:0] {
    HCS_ST_IDLE  = 2'b00,
    HCS_ST_LOOK  = 2'b01,
    HCS_ST_ADD   = 2'b10,
    HCS_ST_CHECK = 2'b11
  } hcs_state_type;
endpackage

// file: rtl/hcs_tbl_if.sv
// Lookup path between the selector and its hopping table
`timescale 1ns/10ps
`default_nettype none
interface hcs_tbl_if;
  import hcs_pkg::*;
  hcs_cn_type index;
  hcs_cn_type carrier;
  modport req (output index, input carrier);
  modport rom (input index, output carrier);
endinterface
`default_nettype wire

// file: rtl/hcs_hop_table.sv
// Registered read port on the fixed hopping table
`timescale 1ns/10ps
`default_nettype none
module hcs_hop_table (
  input  wire logic i_clk,
  hcs_tbl_if.rom    tbl
);
  import hcs_pkg::*;

  typedef struct packed {
    hcs_cn_type carrier;
  } hcs_rom_state_type;

  hcs_rom_state_type s_reg;
  hcs_rom_state_type s_next;

  // Out-of-range index reads carrier zero; callers reduce first
  always_comb
  begin
    s_next = s_reg;
    if (int'(tbl.index) < HCS_NUF)
      s_next.carrier = HCS_HOP_TABLE[tbl.index];
    else
      s_next.carrier = '0;
  end

  // No reset needed: contents are a pure function of the index
  always_ff @(posedge i_clk)
  begin
    s_reg <= s_next;
  end

  assign tbl.carrier = s_reg.carrier;
endmodule
`default_nettype wire

// file: rtl/hcs_selector.sv
// Hop carrier selection, exclusion, antenna and dual-slot diversity
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Carrier = (table((primary+offset) mod 95) + sequence code) mod 95.
// - Fixed 95-entry table maps each index to a distinct carrier.
// - Tuning word is 2401.056 MHz plus carrier times 0.864 MHz.
// - Per-base sequence code shifts the table output.
// - Noisy carriers get marked; at most 20 are excluded from hopping.
// - Preamble picks stronger antenna, held for receive and next transmit.
// - Antenna diversity on by default; a setting forces single antenna.
// - Dual-slot copies: keep the one with fewer CRC errors.
// - No dual-slot on later connections when over 2 handsets registered.
// - Every modulo reduction uses the used frequency count 95.
// - Primary hop index steps by one mod 95 at each half-frame end.
// - Scan slots use zero offset and skip no carrier.
module hcs_selector #(
  parameter int unsigned MAX_EXCL = hcs_pkg::HCS_MAX_EXCL,
  parameter int unsigned RSSI_W   = 8,
  parameter int unsigned ERR_W    = 4
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_slot_start,
  input  wire logic                  i_scan_slot,
  input  wire logic                  i_halfframe_end,
  input  wire hcs_pkg::hcs_cn_type   i_hop_index_offset,
  input  wire hcs_pkg::hcs_cn_type   i_sequence_code,
  input  wire logic                  i_quality_valid,
  input  wire logic                  i_quality_noisy,
  input  wire logic                  i_excl_clear,
  input  wire logic                  i_div_disable,
  input  wire logic                  i_rssi_valid,
  input  wire logic [RSSI_W-1:0]     i_rssi_ant0,
  input  wire logic [RSSI_W-1:0]     i_rssi_ant1,
  input  wire logic [2:0]            i_registered_handsets,
  input  wire logic [2:0]            i_conn_ordinal,
  input  wire logic                  i_copies_valid,
  input  wire logic [ERR_W-1:0]      i_err_copy_a,
  input  wire logic [ERR_W-1:0]      i_err_copy_b,
  output logic                       o_tune_strobe,
  output hcs_pkg::hcs_cn_type        o_carrier_number,
  output logic [21:0]                o_freq_khz,
  output hcs_pkg::hcs_cn_type        o_primary_hop_index,
  output logic [6:0]                 o_excl_count,
  output logic                       o_busy,
  output logic                       o_antenna_sel,
  output logic                       o_dual_slot_en,
  output logic                       o_use_copy_b
);
  import hcs_pkg::*;

  // Elaboration-time guard on parameter values
  if (MAX_EXCL == 0 || MAX_EXCL >= HCS_NUF || RSSI_W == 0 || ERR_W == 0)
  begin : g_bad_param
    $error("hcs_selector: unsupported parameter values");
  end

  localparam logic [6:0] MAX_EXCL_W7 = 7'(MAX_EXCL);

  typedef struct packed {
    hcs_state_type      st;
    hcs_cn_type         primary_hop_index;
    hcs_cn_type         idx;
    hcs_cn_type         sequence_code;
    hcs_cn_type         work;
    logic               scan;
    logic               scan_out;
    hcs_cn_type         cn_out;
    logic [21:0]        freq;
    logic               tune;
    logic [HCS_NUF-1:0] excl;
    logic [6:0]         excl_cnt;
    logic               ant;
    logic               dual;
    logic               use_b;
    logic               busy;
  } hcs_state_reg_type;

  hcs_state_reg_type s_reg;
  hcs_state_reg_type s_next;

  hcs_tbl_if tbl ();

  hcs_hop_table u_table (
    .i_clk (i_clk),
    .tbl   (tbl)
  );

  // Reduce a value below twice the count into 0..94
  function automatic hcs_cn_type mod_nuf(input logic [7:0] v);
    logic [7:0] r;
    r = (v >= HCS_NUF_W8) ? 8'(v - HCS_NUF_W8) : v;
    return r[HCS_CN_W-1:0];
  endfunction

  // Table index is held in a register so the ROM sees a stable address
  assign tbl.index = s_reg.idx;

  always_comb
  begin
    s_next      = s_reg;
    s_next.tune = 1'b0;

    // Frame counter advance, independent of slot work
    if (i_halfframe_end)
      s_next.primary_hop_index = mod_nuf({1'b0, s_reg.primary_hop_index} + HCS_ONE_W8);

    // Noise marking first, so the carrier check sees this edge's map
    if (i_excl_clear)
    begin
      s_next.excl     = '0;
      s_next.excl_cnt = '0;
    end
    // Scan carriers are not judged; a verdict in a clearing cycle still lands
    if (i_quality_valid && i_quality_noisy && !s_reg.scan_out
        && !s_next.excl[s_reg.cn_out] && s_next.excl_cnt < MAX_EXCL_W7)
    begin
      s_next.excl[s_reg.cn_out] = 1'b1;
      s_next.excl_cnt = 7'(s_next.excl_cnt + 7'h01);
    end

    unique case (s_reg.st)
      HCS_ST_IDLE:
        if (i_slot_start)
        begin
          s_next.scan = i_scan_slot;
          s_next.sequence_code  = mod_nuf({1'b0, i_sequence_code});
          // Scan slots force a zero bearer offset
          s_next.idx  = mod_nuf({1'b0, s_reg.primary_hop_index} + (i_scan_slot
                        ? HCS_ZERO_W8
                        : {1'b0, mod_nuf({1'b0, i_hop_index_offset})}));
          s_next.st   = HCS_ST_LOOK;
        end
      HCS_ST_LOOK:
        s_next.st = HCS_ST_ADD;
      HCS_ST_ADD:
      begin
        // Table output plus per-base shift, reduced again
        s_next.work = mod_nuf({1'b0, tbl.carrier} + {1'b0, s_reg.sequence_code});
        s_next.st   = HCS_ST_CHECK;
      end
      HCS_ST_CHECK:
        // Walk upward past excluded carriers; the cap keeps this bounded
        if (!s_reg.scan && s_next.excl[s_reg.work])
          s_next.work = mod_nuf({1'b0, s_reg.work} + HCS_ONE_W8);
        else
        begin
          s_next.cn_out   = s_reg.work;
          s_next.scan_out = s_reg.scan;
          s_next.freq     = HCS_FREQ_BASE
                            + 22'(s_reg.work) * HCS_FREQ_STEP;
          s_next.tune     = 1'b1;
          s_next.st       = HCS_ST_IDLE;
        end
    endcase

    // Antenna choice moves only on a preamble measurement, or to antenna 0 while diversity is disabled
    if (i_div_disable)
      s_next.ant = 1'b0;
    else if (i_rssi_valid)
      s_next.ant = (i_rssi_ant1 > i_rssi_ant0);

    // Dual-slot allowed unless shared among many handsets
    s_next.dual = !((i_registered_handsets > HCS_SHARED_LIM)
                    && (i_conn_ordinal != 3'h0));

    // Ties keep copy a
    if (i_copies_valid && s_reg.dual)
      s_next.use_b = (i_err_copy_b < i_err_copy_a);

    // Busy kept in its own flop so the output has no decode behind it
    s_next.busy = (s_next.st != HCS_ST_IDLE);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg      <= '0;
      s_reg.st   <= HCS_ST_IDLE;
      s_reg.dual <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign o_tune_strobe       = s_reg.tune;
  assign o_carrier_number    = s_reg.cn_out;
  assign o_freq_khz          = s_reg.freq;
  assign o_primary_hop_index = s_reg.primary_hop_index;
  assign o_excl_count        = s_reg.excl_cnt;
  assign o_busy              = s_reg.busy;
  assign o_antenna_sel       = s_reg.ant;
  assign o_dual_slot_en      = s_reg.dual;
  assign o_use_copy_b        = s_reg.use_b;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_primary_hop_index_step: assert property (
    i_halfframe_end |=> o_primary_hop_index ==
      mod_nuf({1'b0, $past(o_primary_hop_index)} + HCS_ONE_W8))
    else $error("primary hop index did not step");
  a_primary_hop_index_hold: assert property (
    !i_halfframe_end |=> $stable(o_primary_hop_index))
    else $error("primary hop index moved without half-frame end");
  a_cn_range: assert property (
    o_tune_strobe |-> int'(o_carrier_number) < HCS_NUF)
    else $error("carrier number out of range");
  a_freq_map: assert property (
    o_tune_strobe |-> o_freq_khz ==
      HCS_FREQ_BASE + 22'(o_carrier_number) * HCS_FREQ_STEP)
    else $error("tuning word does not match carrier");
  a_tune_latency: assert property (
    (i_slot_start && !o_busy) |-> ##[4:25] o_tune_strobe)
    else $error("carrier not ready in time");
  a_no_excluded: assert property (
    (o_tune_strobe && !s_reg.scan_out) |-> !s_reg.excl[o_carrier_number])
    else $error("excluded carrier used");
  a_excl_cap: assert property (
    o_excl_count <= MAX_EXCL_W7 && $countones(s_reg.excl) == int'(o_excl_count))
    else $error("exclusion count wrong");
  a_ant_single: assert property (
    i_div_disable |=> !o_antenna_sel)
    else $error("antenna diversity not disabled");
  a_ant_select: assert property (
    (i_rssi_valid && !i_div_disable) |=> o_antenna_sel ==
      ($past(i_rssi_ant1) > $past(i_rssi_ant0)))
    else $error("weaker antenna selected");
  a_ant_hold: assert property (
    (!i_rssi_valid && !i_div_disable) |=> $stable(o_antenna_sel))
    else $error("antenna changed without measurement");
  a_dual_rule: assert property (
    (i_registered_handsets > HCS_SHARED_LIM && i_conn_ordinal != 3'h0)
      |=> !o_dual_slot_en)
    else $error("dual slot active on shared connection");
  a_copy_pick: assert property (
    (i_copies_valid && o_dual_slot_en) |=> o_use_copy_b ==
      ($past(i_err_copy_b) < $past(i_err_copy_a)))
    else $error("worse copy kept");

  c_tune_normal: cover property (i_slot_start && !i_scan_slot ##4 o_tune_strobe);
  c_tune_skip: cover property (o_tune_strobe && o_excl_count != 7'h00);
  c_excl_full: cover property (o_excl_count == MAX_EXCL_W7);
  c_ant_one: cover property (i_rssi_valid ##1 o_antenna_sel);
endmodule
`default_nettype wire

// file: tb/hcs_radio_model.sv
// Behavioural radio transceiver and antenna switch for the selector bench
`timescale 1ns/10ps
`default_nettype none
module hcs_radio_model (
  input  wire logic       i_clk,
  input  wire logic       i_cmd_rssi,
  input  wire logic [7:0] i_lvl0,
  input  wire logic [7:0] i_lvl1,
  input  wire logic       i_cmd_noisy,
  input  wire logic       i_cmd_quiet,
  output logic            o_rssi_valid,
  output logic [7:0]      o_rssi_ant0,
  output logic [7:0]      o_rssi_ant1,
  output logic            o_quality_valid,
  output logic            o_quality_noisy
);
  // Levels valid one cycle only; stale data flips so it never looks fresh
  always_ff @(posedge i_clk)
  begin
    o_rssi_valid    <= i_cmd_rssi;
    o_quality_valid <= i_cmd_noisy | i_cmd_quiet;
    o_quality_noisy <= i_cmd_noisy;
    o_rssi_ant0     <= i_cmd_rssi ? i_lvl0 : ~o_rssi_ant0;
    o_rssi_ant1     <= i_cmd_rssi ? i_lvl1 : ~o_rssi_ant1;
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the hop carrier selector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hcs_pkg::*;
  logic        i_clk, i_srst, start, scan, hfe, clr, dis, cmd_r, cmd_n;
  logic        cpv, q_v, q_n, cmd_q, r_v, strobe, busy, ant, dual, use_b;
  logic [7:0]  lvl0, lvl1, r0, r1;
  logic [2:0]  hs, ord;
  logic [3:0]  ea, eb;
  hcs_cn_type  hop_index_offset, sequence_code, cn, primary_hop_index;
  logic [6:0]  excl;
  logic [21:0] freq;
  int          fails;
  int          comparisons;

  hcs_selector dut (.i_clk(i_clk), .i_srst(i_srst), .i_slot_start(start),
    .i_scan_slot(scan), .i_halfframe_end(hfe), .i_hop_index_offset(hop_index_offset),
    .i_sequence_code(sequence_code), .i_quality_valid(q_v), .i_quality_noisy(q_n),
    .i_excl_clear(clr), .i_div_disable(dis), .i_rssi_valid(r_v),
    .i_rssi_ant0(r0), .i_rssi_ant1(r1), .i_registered_handsets(hs),
    .i_conn_ordinal(ord), .i_copies_valid(cpv), .i_err_copy_a(ea),
    .i_err_copy_b(eb), .o_tune_strobe(strobe), .o_carrier_number(cn),
    .o_freq_khz(freq), .o_primary_hop_index(primary_hop_index), .o_excl_count(excl),
    .o_busy(busy), .o_antenna_sel(ant), .o_dual_slot_en(dual),
    .o_use_copy_b(use_b));
  hcs_radio_model radio (.i_clk(i_clk), .i_cmd_rssi(cmd_r), .i_lvl0(lvl0),
    .i_lvl1(lvl1), .i_cmd_noisy(cmd_n), .i_cmd_quiet(cmd_q),
    .o_rssi_valid(r_v), .o_rssi_ant0(r0), .o_rssi_ant1(r1),
    .o_quality_valid(q_v), .o_quality_noisy(q_n));

  // Free-running 250 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Inputs move 1 ns after the edge, clear of the sampling instant
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(logic [63:0] got, logic [63:0] exp, string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got,
        exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One slot; a second start mid-computation must be ignored
  task automatic slot(logic [6:0] o, logic [6:0] q, logic s, int c, int l);
    int n;
    hop_index_offset = o;
    sequence_code = q;
    scan = s;
    start = 1'b1;
    tick();
    start = 1'b0;
    n = 1;
    while (strobe !== 1'b1 && n < 40)
    begin
      tick();
      n++;
      start = (n == 2);
    end
    start = 1'b0;
    chk(n, l, "latency");
    chk(cn, c, "carrier");
    chk(freq, 2401056 + c * 864, "frequency");
    tick(2);
    chk({strobe, busy}, 2'b00, "refused start");
  endtask

  task automatic t_carrier;
    slot(7'h01, 7'h00, 1'b0, 23, 4);
    slot(7'h02, 7'h28, 1'b0, 7, 4);
    slot(7'h5e, 7'h5e, 1'b0, 45, 4);
    slot(7'h60, 7'h00, 1'b0, 23, 4);
    slot(7'h00, 7'h64, 1'b0, 5, 4);
    $display("test carrier done");
  endtask

  // Quality verdict on the carrier in use, noisy or quiet, through the radio
  task automatic mark(logic nz, int exp);
    cmd_n = nz;
    cmd_q = !nz;
    tick();
    cmd_n = 1'b0;
    cmd_q = 1'b0;
    tick();
    chk(excl, exp, "excluded count");
  endtask

  task automatic t_excl;
    mark(1'b0, 0);
    mark(1'b1, 1);
    mark(1'b1, 1);
    slot(7'h00, 7'h64, 1'b0, 6, 5);
    slot(7'h07, 7'h64, 1'b1, 5, 4);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    chk(excl, 0, "cleared count");
    mark(1'b1, 0);
    slot(7'h00, 7'h64, 1'b0, 5, 4);
    // Fill the map to its cap; one more verdict must be refused
    for (int k = 0; k < 21; k++)
    begin
      slot(7'h00, 7'(k), 1'b0, k, 4);
      mark(1'b1, (k < 20) ? k + 1 : 20);
    end
    slot(7'h00, 7'h00, 1'b0, 20, 24);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    chk(excl, 0, "cleared count");
    $display("test exclusion done");
  endtask

  task automatic rssi(logic [7:0] a, logic [7:0] b, logic exp);
    lvl0 = a;
    lvl1 = b;
    cmd_r = 1'b1;
    tick();
    cmd_r = 1'b0;
    tick();
    chk(ant, exp, "antenna");
  endtask

  task automatic t_ant;
    rssi(8'h0a, 8'h0a, 1'b0);
    rssi(8'h0a, 8'h0b, 1'b1);
    rssi(8'hc8, 8'h03, 1'b0);
    rssi(8'h03, 8'hc8, 1'b1);
    dis = 1'b1;
    tick();
    chk(ant, 0, "single antenna");
    rssi(8'h03, 8'hc8, 1'b0);
    dis = 1'b0;
    $display("test antenna done");
  endtask

  task automatic copy(logic [2:0] h, logic [2:0] o, logic [3:0] a,
    logic [3:0] b, logic en, logic exp);
    hs = h;
    ord = o;
    tick();
    chk(dual, en, "dual slot enable");
    ea = a;
    eb = b;
    cpv = 1'b1;
    tick();
    cpv = 1'b0;
    chk(use_b, exp, "copy choice");
  endtask

  task automatic t_dual;
    copy(3'h3, 3'h1, 4'h5, 4'h2, 1'b0, 1'b0);
    copy(3'h3, 3'h0, 4'h5, 4'h2, 1'b1, 1'b1);
    copy(3'h2, 3'h3, 4'h2, 4'h2, 1'b1, 1'b0);
    copy(3'h6, 3'h2, 4'h9, 4'h1, 1'b0, 1'b0);
    $display("test dual slot done");
  endtask

  // Back-to-back half-frame ends wrap the index past 94
  task automatic t_hop;
    hfe = 1'b1;
    tick(97);
    hfe = 1'b0;
    chk(primary_hop_index, 2, "hop index");
    slot(7'h5e, 7'h00, 1'b0, 23, 4);
    hfe = 1'b1;
    tick(93);
    hfe = 1'b0;
    chk(primary_hop_index, 0, "hop index wrap");
    $display("test hop index done");
  endtask

  // Watchdog sized well above the expected run of under 2000 cycles
  initial
  begin
    #40000;
    fails++;
    final_report();
  end

  initial
  begin
    {i_srst, start, scan, hfe, clr, dis, cmd_r, cmd_n, cpv} = 9'h1ff;
    {start, scan, hfe, clr, dis, cmd_r, cmd_n, cpv} = 8'h00;
    {hop_index_offset, sequence_code, lvl0, lvl1, ea, eb} = 38'h0;
    hs = 3'h1;
    ord = 3'h0;
    cmd_q = 1'b0;
    tick(16);
    i_srst = 1'b0;
    tick();
    chk({strobe, cn, freq, primary_hop_index, excl, busy, ant, use_b}, 0, "reset");
    chk(dual, 1, "reset dual");
    $display("test reset done");
    t_carrier();
    t_excl();
    t_ant();
    t_dual();
    t_hop();
    final_report();
  end
endmodule
`default_nettype wire
